// ==== gstc_pkg.sv ====
// -----------------------------------------------------------------------------
// Shared constants and carriers for the service table command interpreter.
// -----------------------------------------------------------------------------
package gstc_pkg;

	// Table capacity.
	localparam int GSTC_MAX_PRIV = 4;
	localparam int GSTC_MAX_PUB = 6;
	localparam int GSTC_MAX_CHR = 8;

	// Legal range of the maximum value size in octets.
	localparam logic [7:0] GSTC_SIZE_MIN = 8'h01;
	localparam logic [7:0] GSTC_SIZE_MAX = 8'h14;

	// Leading command letters, ASCII.
	localparam logic [7:0] GSTC_LEAD_CFG = 8'h50;
	localparam logic [7:0] GSTC_LEAD_LIST = 8'h4C;
	localparam logic [7:0] GSTC_LEAD_SET = 8'h53;

	// Parsed commands.
	typedef enum logic [2:0] {
		GSTC_OP_SHOW_SCRIPT,
		GSTC_OP_ADD_CHR,
		GSTC_OP_DECL_SVC,
		GSTC_OP_CLEAR,
		GSTC_OP_SET_DEFAULT
	} gstc_op_t;

	typedef struct packed {
		logic [7:0] lead;
		gstc_op_t op;
		logic syntax_err;
		logic uuid_is_128;
		logic [127:0] uuid;
		logic [7:0] prop;
		logic [7:0] size;
	} gstc_cmd_t;

	// Records of the script listing.
	typedef enum logic [1:0] {
		GSTC_REC_SVC,
		GSTC_REC_CHR,
		GSTC_REC_END
	} gstc_rec_kind_t;

	typedef struct packed {
		gstc_rec_kind_t kind;
		logic uuid_is_128;
		logic [127:0] uuid;
		logic [7:0] prop;
		logic [7:0] size;
	} gstc_rec_t;

endpackage : gstc_pkg

// ==== gstc_service_table.sv ====
// -----------------------------------------------------------------------------
// Overview of operation
// R1 - Script listing streams stored table contents.
// R2 - Every listing ends with an END record.
// R3 - Configuration commands share one leading letter.
// R4 - Table lives in nonvolatile store, survives reboot.
// R5 - Default service change erases custom table.
// R6 - Host sets default services before configuring.
// R7 - Add characteristic carries 16 or 128-bit UUID.
// R8 - Second parameter is stored property bitmap.
// R9 - Size parameter valid only 1 to 20.
// R10 - Host declares a service before adding characteristics.
// R11 - Characteristic UUID width matches service width.
// R12 - Each add appends one, never overwrites.
// R13 - Four private, six public, eight characteristics each.
// R14 - Add answers success, or failure on error.
// R15 - Service declaration takes one 16/128-bit UUID.
// R16 - Declaration fails on error or full table.
// R17 - Service live only with characteristic, after reboot.
// R18 - Clear erases all definitions, answers success.
// R19 - Cleared table takes effect only after reboot.
// R20 - Host clears, then declares and adds per service.
// R21 - Add without declared service fails, table unchanged.
// -----------------------------------------------------------------------------
`timescale 1ns/1ps

module gstc_service_table import gstc_pkg::*; #(
	parameter int MAX_PRIV = GSTC_MAX_PRIV,
	parameter int MAX_PUB = GSTC_MAX_PUB,
	parameter int MAX_CHR = GSTC_MAX_CHR
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Reboot request, a one-cycle pulse from the same clock domain.
	input wire logic i_reboot,
	// Parsed command stream.
	input wire logic i_cmd_valid,
	input wire gstc_cmd_t i_cmd,
	output logic o_cmd_ready,
	// Reply to every command except a script listing request with a good lead letter and no syntax error.
	output logic o_reply_valid,
	output logic o_reply_ok,
	// Script listing records.
	output logic o_list_valid,
	output gstc_rec_t o_list_rec,
	input wire logic i_list_ready,
	// Number of services in effect since the last reboot.
	output logic [7:0] o_live_services
);

	localparam int NSVC = MAX_PRIV + MAX_PUB;
	localparam int NCHR = NSVC * MAX_CHR;
	localparam int SW = $clog2(NSVC + 1);
	localparam int CW = $clog2(MAX_CHR + 1);
	localparam int AW = $clog2(NCHR);

	// -------------------------------------------------------------------------
	// Parameter checks.
	// -------------------------------------------------------------------------
	if (MAX_PRIV < 1 || MAX_PUB < 1 || MAX_CHR < 1 || NSVC > 255) begin : g_bad_param
		$error("Service table capacity parameters out of range.");
	end

	typedef enum {S_IDLE, S_LSVC, S_LCHR, S_LDONE} gstc_state_t;

	// -------------------------------------------------------------------------
	// Storage. The arrays model the nonvolatile store and carry no reset. // see R4
	// -------------------------------------------------------------------------
	logic [127:0] svc_uuid_mem [NSVC];
	logic svc_is128_mem [NSVC];
	logic [CW-1:0] svc_nchr_mem [NSVC];
	logic [127:0] chr_uuid_mem [NCHR];
	logic [7:0] chr_prop_mem [NCHR];
	logic [7:0] chr_size_mem [NCHR];

	logic [SW-1:0] svc_cnt_ff;
	logic [SW-1:0] priv_cnt_ff;
	logic [SW-1:0] pub_cnt_ff;
	logic [SW-1:0] cur_svc_ff;
	logic cur_valid_ff;
	gstc_state_t state_ff;
	logic [SW-1:0] lst_svc_ff;
	logic [CW-1:0] lst_chr_ff;
	logic [7:0] live_ff;
	logic reply_valid_ff;
	logic reply_ok_ff;
	logic list_valid_ff;
	gstc_rec_t list_rec_ff;

	logic accept;
	logic lead_ok;
	logic size_ok;
	logic add_ok;
	logic decl_ok;
	logic erase_ok;
	logic [CW-1:0] cur_nchr;
	logic [AW-1:0] add_addr;
	logic [AW-1:0] lst_addr;
	logic list_free;
	logic [7:0] nxt_live;

	// -------------------------------------------------------------------------
	// Command decode and checks.
	// -------------------------------------------------------------------------
	assign o_cmd_ready = (state_ff == S_IDLE);
	assign accept = i_cmd_valid && o_cmd_ready;
	assign cur_nchr = svc_nchr_mem[cur_svc_ff];
	assign add_addr = AW'(int'(cur_svc_ff) * MAX_CHR + int'(cur_nchr));
	assign lst_addr = AW'(int'(lst_svc_ff) * MAX_CHR + int'(lst_chr_ff));

	// Each command group is recognised by its own leading letter. // see R3
	always_comb begin
		case (i_cmd.op)
			GSTC_OP_SHOW_SCRIPT: lead_ok = (i_cmd.lead == GSTC_LEAD_LIST);
			GSTC_OP_SET_DEFAULT: lead_ok = (i_cmd.lead == GSTC_LEAD_SET);
			default: lead_ok = (i_cmd.lead == GSTC_LEAD_CFG);
		endcase
	end

	assign size_ok = (i_cmd.size >= GSTC_SIZE_MIN) && (i_cmd.size <= GSTC_SIZE_MAX); // see R9

	// A characteristic needs a declared service of the same UUID width and room. // see R7
	assign add_ok = lead_ok && !i_cmd.syntax_err && cur_valid_ff // see R21
		&& (i_cmd.uuid_is_128 == svc_is128_mem[cur_svc_ff]) // see R11
		&& size_ok && (int'(cur_nchr) < MAX_CHR); // see R13

	// A service needs room in the pool of its own width. // see R15
	assign decl_ok = lead_ok && !i_cmd.syntax_err
		&& (i_cmd.uuid_is_128 ? int'(priv_cnt_ff) < MAX_PRIV
			: int'(pub_cnt_ff) < MAX_PUB); // see R16

	assign erase_ok = lead_ok && !i_cmd.syntax_err;

	// -------------------------------------------------------------------------
	// Table writes. Appends only ever go to the next free slot. // see R12
	// -------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (accept && i_cmd.op == GSTC_OP_ADD_CHR && add_ok) begin
			chr_uuid_mem[add_addr] <= i_cmd.uuid;
			chr_prop_mem[add_addr] <= i_cmd.prop; // see R8
			chr_size_mem[add_addr] <= i_cmd.size;
			svc_nchr_mem[cur_svc_ff] <= cur_nchr + CW'(1); // see R12
		end else if (accept && i_cmd.op == GSTC_OP_DECL_SVC && decl_ok) begin
			svc_uuid_mem[svc_cnt_ff] <= i_cmd.uuid;
			svc_is128_mem[svc_cnt_ff] <= i_cmd.uuid_is_128;
			svc_nchr_mem[svc_cnt_ff] <= '0;
		end
	end

	// Service counts. Clear and default selection both wipe the table. // see R5
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			svc_cnt_ff <= '0;
			priv_cnt_ff <= '0;
			pub_cnt_ff <= '0;
		end else if (accept && erase_ok
			&& (i_cmd.op == GSTC_OP_CLEAR || i_cmd.op == GSTC_OP_SET_DEFAULT)) begin
			svc_cnt_ff <= '0; // see R18
			priv_cnt_ff <= '0;
			pub_cnt_ff <= '0;
		end else if (accept && i_cmd.op == GSTC_OP_DECL_SVC && decl_ok) begin
			svc_cnt_ff <= svc_cnt_ff + SW'(1);
			if (i_cmd.uuid_is_128) begin
				priv_cnt_ff <= priv_cnt_ff + SW'(1);
			end else begin
				pub_cnt_ff <= pub_cnt_ff + SW'(1);
			end
		end
	end

	// Current service pointer. A reboot closes the open declaration.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cur_svc_ff <= '0;
			cur_valid_ff <= 1'b0;
		end else if (i_reboot) begin
			cur_valid_ff <= 1'b0;
		end else if (accept && erase_ok
			&& (i_cmd.op == GSTC_OP_CLEAR || i_cmd.op == GSTC_OP_SET_DEFAULT)) begin
			cur_valid_ff <= 1'b0;
		end else if (accept && i_cmd.op == GSTC_OP_DECL_SVC && decl_ok) begin
			cur_svc_ff <= svc_cnt_ff;
			cur_valid_ff <= 1'b1;
		end
	end

	// -------------------------------------------------------------------------
	// Live view. Only services holding a characteristic count, and the
	// count moves only on reboot, so edits and clears wait for it. // see R17
	// -------------------------------------------------------------------------
	always_comb begin
		nxt_live = '0;
		for (int i = 0; i < NSVC; i++) begin
			if (i < int'(svc_cnt_ff) && svc_nchr_mem[i] != '0) begin
				nxt_live = nxt_live + 8'h01;
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			live_ff <= '0;
		end else if (i_reboot) begin
			live_ff <= nxt_live; // see R19
		end
	end

	assign o_live_services = live_ff;

	// -------------------------------------------------------------------------
	// Reply, one cycle after the command is taken. // see R14
	// -------------------------------------------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			reply_valid_ff <= 1'b0;
			reply_ok_ff <= 1'b0;
		end else begin
			reply_valid_ff <= accept && !(i_cmd.op == GSTC_OP_SHOW_SCRIPT && erase_ok);
			case (i_cmd.op)
				GSTC_OP_ADD_CHR: reply_ok_ff <= add_ok;
				GSTC_OP_DECL_SVC: reply_ok_ff <= decl_ok; // see R16
				GSTC_OP_CLEAR: reply_ok_ff <= erase_ok; // see R18
				GSTC_OP_SET_DEFAULT: reply_ok_ff <= erase_ok;
				default: reply_ok_ff <= 1'b0;
			endcase
		end
	end

	assign o_reply_valid = reply_valid_ff;
	assign o_reply_ok = reply_ok_ff;

	// -------------------------------------------------------------------------
	// Script listing. A record is loaded only when the output slot is free,
	// which lets the host stall the walk for as long as it likes. // see R1
	// -------------------------------------------------------------------------
	assign list_free = !list_valid_ff || i_list_ready;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= S_IDLE;
			lst_svc_ff <= '0;
			lst_chr_ff <= '0;
			list_valid_ff <= 1'b0;
			list_rec_ff <= '0;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (accept && i_cmd.op == GSTC_OP_SHOW_SCRIPT && erase_ok) begin
						lst_svc_ff <= '0;
						state_ff <= S_LSVC;
					end
				end
				S_LSVC: begin
					if (list_free) begin
						list_valid_ff <= 1'b1;
						list_rec_ff.prop <= '0;
						list_rec_ff.size <= '0;
						lst_chr_ff <= '0;
						if (lst_svc_ff < svc_cnt_ff) begin
							list_rec_ff.kind <= GSTC_REC_SVC;
							list_rec_ff.uuid <= svc_uuid_mem[lst_svc_ff];
							list_rec_ff.uuid_is_128 <= svc_is128_mem[lst_svc_ff];
							state_ff <= S_LCHR;
						end else begin
							list_rec_ff.kind <= GSTC_REC_END; // see R2
							list_rec_ff.uuid <= '0;
							list_rec_ff.uuid_is_128 <= 1'b0;
							state_ff <= S_LDONE;
						end
					end
				end
				S_LCHR: begin
					if (list_free) begin
						if (lst_chr_ff < svc_nchr_mem[lst_svc_ff]) begin
							list_valid_ff <= 1'b1;
							list_rec_ff.kind <= GSTC_REC_CHR;
							list_rec_ff.uuid <= chr_uuid_mem[lst_addr];
							list_rec_ff.prop <= chr_prop_mem[lst_addr];
							list_rec_ff.size <= chr_size_mem[lst_addr];
							lst_chr_ff <= lst_chr_ff + CW'(1);
						end else begin
							list_valid_ff <= 1'b0;
							lst_svc_ff <= lst_svc_ff + SW'(1);
							state_ff <= S_LSVC;
						end
					end
				end
				S_LDONE: begin
					if (list_free) begin
						list_valid_ff <= 1'b0;
						state_ff <= S_IDLE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	assign o_list_valid = list_valid_ff;
	assign o_list_rec = list_rec_ff;

	// -------------------------------------------------------------------------
	// Assertions.
	// -------------------------------------------------------------------------
	a_lead_letter: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R3
		accept && !lead_ok |=> o_reply_valid && !o_reply_ok)
		else $error("Command with a wrong leading letter was accepted.");

	a_size_range: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R9
		accept && i_cmd.op == GSTC_OP_ADD_CHR && !size_ok |=> o_reply_valid && !o_reply_ok)
		else $error("Out of range size was not refused.");

	a_width_match: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R11
		accept && i_cmd.op == GSTC_OP_ADD_CHR && cur_valid_ff
		&& i_cmd.uuid_is_128 != svc_is128_mem[cur_svc_ff] |=> !o_reply_ok)
		else $error("Characteristic of the wrong UUID width was accepted.");

	a_no_service: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R21
		accept && i_cmd.op == GSTC_OP_ADD_CHR && !cur_valid_ff
		|=> o_reply_valid && !o_reply_ok && $stable(svc_cnt_ff))
		else $error("Characteristic added with no declared service.");

	a_add_append: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R12
		accept && i_cmd.op == GSTC_OP_ADD_CHR && add_ok && !i_reboot
		|=> cur_nchr == $past(cur_nchr) + CW'(1) && o_reply_ok)
		else $error("Accepted characteristic was not appended.");

	a_capacity: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R13
		int'(priv_cnt_ff) <= MAX_PRIV && int'(pub_cnt_ff) <= MAX_PUB
		&& int'(cur_nchr) <= MAX_CHR)
		else $error("Service table capacity exceeded.");

	a_clear_wipes: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R18
		accept && (i_cmd.op == GSTC_OP_CLEAR || i_cmd.op == GSTC_OP_SET_DEFAULT) && erase_ok
		|=> svc_cnt_ff == '0 && !cur_valid_ff && o_reply_valid && o_reply_ok)
		else $error("Clear or default selection left services behind.");

	a_clear_deferred: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R19
		accept && i_cmd.op == GSTC_OP_CLEAR && !i_reboot |=> $stable(o_live_services))
		else $error("Clear took effect before a reboot.");

	a_list_ends: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R2
		o_list_valid && o_list_rec.kind == GSTC_REC_END && i_list_ready
		|=> !o_list_valid && o_cmd_ready)
		else $error("Listing did not finish after its END record.");

	a_list_starts: assert property (@(posedge i_core_clk) disable iff (i_rst) // see R1
		accept && i_cmd.op == GSTC_OP_SHOW_SCRIPT && lead_ok && !i_cmd.syntax_err
		|=> !o_reply_valid ##1 o_list_valid)
		else $error("Script listing did not start.");

endmodule : gstc_service_table

// ==== gstc_host_model.sv ====
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Host controller model issuing configuration commands.
// -----------------------------------------------------------------------------
module gstc_host_model import gstc_pkg::*; (
	// Clock.
	input wire logic i_core_clk,
	// Command side.
	output logic o_cmd_valid,
	output gstc_cmd_t o_cmd,
	input wire logic i_cmd_ready,
	input wire logic i_reply_valid,
	input wire logic i_reply_ok,
	// Listing side.
	input wire logic i_list_valid,
	input wire gstc_rec_t i_list_rec,
	output logic o_list_ready
);
	gstc_rec_t recs[$];

	// The bus starts idle with nothing offered.
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
		o_list_ready = 1'b0;
	end

	// Holds a command until taken, then samples the reply one cycle later.
	// A released bus shows the inverse so stale values cannot pass as a command.
	task automatic send(input gstc_cmd_t c, output logic rv, output logic ok, output logic hung);
		int n;
		hung = 1'b1;
		rv = 1'b0;
		ok = 1'b0;
		@(posedge i_core_clk);
		o_cmd_valid <= 1'b1;
		o_cmd <= c;
		for (n = 0; n < 64 && hung; n++) begin
			@(negedge i_core_clk);
			if (i_cmd_ready === 1'b1) begin
				hung = 1'b0;
			end
		end
		@(posedge i_core_clk);
		o_cmd_valid <= 1'b0;
		o_cmd <= ~c;
		@(negedge i_core_clk);
		rv = i_reply_valid;
		ok = i_reply_ok;
	endtask : send

	// Collects listing records until END; a slow host stalls two cycles of three.
	task automatic list(input logic slow, output logic hung);
		int n;
		recs.delete();
		hung = 1'b1;
		for (n = 0; n < 400 && hung; n++) begin
			@(posedge i_core_clk);
			o_list_ready <= !(slow && (n % 3 != 2));
			@(negedge i_core_clk);
			if (i_list_valid === 1'b1 && o_list_ready === 1'b1) begin
				recs.push_back(i_list_rec);
				if (i_list_rec.kind === GSTC_REC_END) begin
					hung = 1'b0;
				end
			end
		end
		@(posedge i_core_clk);
		o_list_ready <= 1'b0;
	endtask : list

endmodule : gstc_host_model

// ==== test_gstc_service_table.sv ====
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Testbench for the service table command interpreter.
// -----------------------------------------------------------------------------
module test_gstc_service_table import gstc_pkg::*; ;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_reboot = 1'b0;
	logic cmd_valid, cmd_ready, reply_valid, reply_ok, list_valid, list_ready;
	gstc_cmd_t cmd;
	gstc_rec_t list_rec;
	logic [7:0] live;
	int error_cnt = 0;
	int compares = 0;

	// Clock at 200 MHz.
	always #2.5 i_core_clk = ~i_core_clk;

	gstc_service_table u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reboot(i_reboot),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
		.o_reply_valid(reply_valid), .o_reply_ok(reply_ok), .o_list_valid(list_valid),
		.o_list_rec(list_rec), .i_list_ready(list_ready), .o_live_services(live));

	gstc_host_model u_host (.i_core_clk(i_core_clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
		.i_cmd_ready(cmd_ready), .i_reply_valid(reply_valid), .i_reply_ok(reply_ok),
		.i_list_valid(list_valid), .i_list_rec(list_rec), .o_list_ready(list_ready));

	// -------------------------------------------------------------------------
	// Reporting and comparison.
	// -------------------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// Compares one flag.
	task automatic chk1(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk1

	// Compares one byte.
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8

	// Compares one listing record; END carries only its kind.
	task automatic chk_rec(input int i, input gstc_rec_kind_t k, input logic [15:0] u,
		input logic [7:0] p, input logic [7:0] s);
		gstc_rec_t r;
		r = u_host.recs[i];
		compares++;
		if (r.kind !== k || (k != GSTC_REC_END && (r.uuid_is_128 !== 1'b0 ||
			r.uuid !== {112'h0, u} || r.prop !== p || r.size !== s))) begin
			error_cnt++;
			$display("[ERR] %0t listing record %0d wrong", $time, i);
		end
	endtask : chk_rec

	// Counts a wait that ran out and closes the run.
	task automatic fail_hang();
		error_cnt++;
		$display("[ERR] %0t wait timed out", $time);
		finish_test();
	endtask : fail_hang

	// -------------------------------------------------------------------------
	// Command helpers.
	// -------------------------------------------------------------------------
	// Sends one command and checks the one-cycle reply and its code.
	task automatic send(input logic [7:0] ld, input gstc_op_t op, input logic syn,
		input logic w, input logic [127:0] u, input logic [7:0] p, input logic [7:0] s,
		input logic exp);
		logic rv, ok, hung;
		u_host.send('{ld, op, syn, w, u, p, s}, rv, ok, hung);
		if (hung)
			fail_hang();
		chk1(rv, 1'b1, "reply pulse");
		chk1(ok, exp, "reply code");
	endtask : send

	// Declares a service with a good lead letter.
	task automatic decl(input logic w, input logic [127:0] u, input logic exp);
		send(GSTC_LEAD_CFG, GSTC_OP_DECL_SVC, 1'b0, w, u, 8'h00, 8'h00, exp);
	endtask : decl

	// Adds a characteristic with a good lead letter.
	task automatic add(input logic w, input logic [127:0] u, input logic [7:0] p,
		input logic [7:0] s, input logic exp);
		send(GSTC_LEAD_CFG, GSTC_OP_ADD_CHR, 1'b0, w, u, p, s, exp);
	endtask : add

	// Clears the table, expecting success.
	task automatic clear();
		send(GSTC_LEAD_CFG, GSTC_OP_CLEAR, 1'b0, 1'b0, '0, 8'h00, 8'h00, 1'b1);
	endtask : clear

	// Pulses reboot for one cycle; the live count is sampled after it lands.
	task automatic reboot(input logic [7:0] exp);
		@(posedge i_core_clk);
		i_reboot <= 1'b1;
		@(posedge i_core_clk);
		i_reboot <= 1'b0;
		@(negedge i_core_clk);
		chk8(live, exp, "live services");
	endtask : reboot

	// Requests the script listing, which must not answer with a reply pulse.
	task automatic show(input logic slow, input logic [7:0] n);
		logic rv, ok, hung;
		u_host.send('{GSTC_LEAD_LIST, GSTC_OP_SHOW_SCRIPT, 1'b0, 1'b0, '0, 8'h00, 8'h00},
			rv, ok, hung);
		if (hung)
			fail_hang();
		chk1(rv, 1'b0, "listing reply");
		chk1(cmd_ready, 1'b0, "ready during listing");
		u_host.list(slow, hung);
		if (hung)
			fail_hang();
		chk8(8'(u_host.recs.size()), n, "record count");
	endtask : show

	// -------------------------------------------------------------------------
	// Scenarios.
	// -------------------------------------------------------------------------
	// Adding with no declared service fails and leaves the listing empty.
	task automatic t_no_service();
		add(1'b0, 128'h2A19, 8'h02, 8'h05, 1'b0);
		show(1'b0, 8'h01);
		chk_rec(0, GSTC_REC_END, 16'h0, 8'h00, 8'h00);
	endtask : t_no_service

	// Parameter checks on one public service, then a stalled listing after reboot.
	task automatic t_basic();
		clear();
		decl(1'b0, 128'h180F, 1'b1);
		add(1'b0, 128'h2A19, 8'h1A, 8'h05, 1'b1);
		add(1'b1, 128'h1122334455667788, 8'h02, 8'h05, 1'b0);
		add(1'b0, 128'h2A1A, 8'h02, 8'h00, 1'b0);
		add(1'b0, 128'h2A1A, 8'h02, 8'h15, 1'b0);
		add(1'b0, 128'h2A1B, 8'h10, 8'h14, 1'b1);
		send(8'h51, GSTC_OP_ADD_CHR, 1'b0, 1'b0, 128'h2A1C, 8'h02, 8'h01, 1'b0);
		send(GSTC_LEAD_CFG, GSTC_OP_ADD_CHR, 1'b1, 1'b0, 128'h2A1C, 8'h02, 8'h01, 1'b0);
		send(8'h51, GSTC_OP_DECL_SVC, 1'b0, 1'b0, 128'h180A, 8'h00, 8'h00, 1'b0);
		chk8(live, 8'h00, "live before reboot");
		reboot(8'h01);
		show(1'b1, 8'h04);
		chk_rec(0, GSTC_REC_SVC, 16'h180F, 8'h00, 8'h00);
		chk_rec(1, GSTC_REC_CHR, 16'h2A19, 8'h1A, 8'h05);
		chk_rec(2, GSTC_REC_CHR, 16'h2A1B, 8'h10, 8'h14);
		chk_rec(3, GSTC_REC_END, 16'h0, 8'h00, 8'h00);
		add(1'b0, 128'h2A1C, 8'h02, 8'h01, 1'b0);
	endtask : t_basic

	// Fills characteristics and both service pools to their limits.
	task automatic t_capacity();
		int i;
		clear();
		reboot(8'h00);
		decl(1'b1, 128'h0102030405060708090A0B0C0D0E0F, 1'b1);
		for (i = 0; i < 8; i++)
			add(1'b1, 128'hA0 + 128'(i), 8'h02, 8'h01, 1'b1);
		add(1'b1, 128'hB0, 8'h02, 8'h01, 1'b0);
		for (i = 0; i < 3; i++)
			decl(1'b1, 128'hC0 + 128'(i), 1'b1);
		decl(1'b1, 128'hCF, 1'b0);
		for (i = 0; i < 6; i++)
			decl(1'b0, 128'h1800 + 128'(i), 1'b1);
		decl(1'b0, 128'h18FF, 1'b0);
		reboot(8'h01);
	endtask : t_capacity

	// Clear answers at once but only takes effect at the next reboot.
	task automatic t_clear();
		clear();
		chk8(live, 8'h01, "live after clear");
		send(GSTC_LEAD_CFG, GSTC_OP_SHOW_SCRIPT, 1'b0, 1'b0, '0, 8'h00, 8'h00, 1'b0);
		reboot(8'h00);
		show(1'b0, 8'h01);
	endtask : t_clear

	// Default services set first keep later custom ones; a later change erases them.
	task automatic t_default();
		send(GSTC_LEAD_SET, GSTC_OP_SET_DEFAULT, 1'b0, 1'b0, '0, 8'h00, 8'h00, 1'b1);
		decl(1'b0, 128'h180A, 1'b1);
		add(1'b0, 128'h2A29, 8'h02, 8'h04, 1'b1);
		reboot(8'h01);
		send(GSTC_LEAD_SET, GSTC_OP_SET_DEFAULT, 1'b0, 1'b0, '0, 8'h00, 8'h00, 1'b1);
		reboot(8'h00);
	endtask : t_default

	// Reset for two cycles, then the scenarios in turn.
	initial begin
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		t_no_service();
		t_basic();
		t_capacity();
		t_clear();
		t_default();
		finish_test();
	end

endmodule : test_gstc_service_table
